// >>> core/byte_sum.v
`timescale 1ns/1ps
`default_nettype none
`include "framer_regs.vh"

module byte_sum (
  input  wire       clock,  // System clock
  input  wire       rst_n,  // Synchronous reset, active low
  input  wire       ce,     // Clock enable
  input  wire       clear,  // Restart the sum
  input  wire       add,    // Add data to the sum
  input  wire [7:0] data,   // Byte to add
  output reg  [7:0] sum     // Low eight bits of the running sum
);

  ////////////////////////////////////////////////////////////////////////////
  // Running modulo-256 sum, clear has priority over add
  always @(posedge clock) begin
    if (!rst_n) begin
      sum <= `SUM_RESET;
    end else if (ce) begin
      if (clear) begin
        sum <= `SUM_RESET;
      end else if (add) begin
        sum <= sum + data;
      end
    end
  end

endmodule
`default_nettype wire

// >>> core/framer_regs.vh
`ifndef FRAMER_REGS_VH
`define FRAMER_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Frame bytes and type codes
`define START_DELIM        8'h7E
`define TYPE_REMOTE_REQ    8'h17
`define TYPE_REMOTE_RESP   8'h97
`define CKSUM_BASE         8'hFF
`define SUM_RESET          8'h00
`define BYTE_ZERO          8'h00
`define FRAME_ID_NONE      8'h00
`define RESP_STATUS_OK     8'h00

////////////////////////////////////////////////////////////////////////////////
// Byte offsets inside a request frame
`define OFS_FIRST_SUMMED   16'h0003
`define OFS_FRAME_ID       16'h0004
`define OFS_DEST64         16'h0005
`define OFS_DEST16         16'h000D
`define OFS_OPTIONS        16'h000F
`define OFS_CMD_HI         16'h0010
`define OFS_CMD_LO         16'h0011
`define OFS_VALUE          16'h0012
`define BODY_LAST_ADJ      16'h0002
`define MIN_BODY_LEN       16'h000F
`define LEN_EMPTY          16'h0000
`define COUNT_ONE          16'h0001
`define COUNT_ZERO         16'h0000

////////////////////////////////////////////////////////////////////////////////
// Option bits and commands
`define OPT_NO_ACK         0
`define OPT_APPLY          1
`define OPT_SECURE         4
`define APPLY_PENDING_CHANGES_CMD 16'h4143

////////////////////////////////////////////////////////////////////////////////
// Response frame shape
`define RESP_LEN_SET       16'h0005
`define RESP_LEN_QUERY     16'h0009
`define RESP_HDR_BYTES     16'h0003

////////////////////////////////////////////////////////////////////////////////
// Register map, byte addresses
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_COUNT          8'h08
`define REG_ACTIVE_CMD     8'h0C
`define REG_ACTIVE_VALUE   8'h10
`define REG_PENDING_CMD    8'h14
`define REG_PENDING_VALUE  8'h18
`define REG_DEST           8'h1C
`define CTRL_RESET         32'h0000_0001
`define CTRL_ENABLE_BIT    0
`define WORD_ZERO          32'h0000_0000
`define HALF_ZERO          16'h0000
`define DEST64_RESET       64'h0000_0000_0000_0000

`endif

// >>> core/remote_cmd_request_framer.v
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "framer_regs.vh"

module remote_cmd_request_framer #(
  parameter ADDR_WIDTH = 8  // APB address width
) (
  input  wire                  clock,    // 100 MHz system clock
  input  wire                  rst_n,    // Synchronous reset, active low
  input  wire                  ce,       // Clock enable, freezes all state
  input  wire                  rxValid,  // Host request byte valid
  input  wire [7:0]            rxData,   // Host request byte
  output reg                   rxReady,  // Block takes a request byte
  output wire                  txValid,  // Response byte valid
  output wire [7:0]            txData,   // Response byte
  input  wire                  txReady,  // Host takes a response byte
  input  wire [ADDR_WIDTH-1:0] paddr,    // APB address
  input  wire                  psel,     // APB select
  input  wire                  penable,  // APB access phase
  input  wire                  pwrite,   // APB write
  input  wire [31:0]           pwdata,   // APB write data
  output reg  [31:0]           prdata,   // APB read data
  output reg                   pready,   // APB ready
  output reg                   pslverr   // APB error on unmapped address
);

  ////////////////////////////////////////////////////////////////////////////
  // Parser states, one-hot
  localparam [5:0] ST_HUNT  = 6'b00_0001;
  localparam [5:0] ST_LENHI = 6'b00_0010;
  localparam [5:0] ST_LENLO = 6'b00_0100;
  localparam [5:0] ST_BODY  = 6'b00_1000;
  localparam [5:0] ST_CKSUM = 6'b01_0000;
  localparam [5:0] ST_RESP  = 6'b10_0000;

  reg  [5:0]  state;        // Parser state
  reg  [15:0] lenReg;       // Body length of the frame
  reg  [15:0] ofs;          // Offset of the next body byte
  reg  [7:0]  typeByte;     // Frame type
  reg  [7:0]  frameId;      // Correlation identifier
  reg  [63:0] dest64;       // Long destination address
  reg  [15:0] dest16;       // Short destination address
  reg  [7:0]  options;      // Option byte of the current frame
  reg  [15:0] cmdWord;      // Two command characters
  reg  [31:0] paramVal;     // Last four value bytes
  reg  [95:0] respVec;      // Response bytes still to send
  reg  [15:0] respCount;    // Response bytes sent
  reg  [15:0] respTotal;    // Response bytes before the checksum
  reg  [31:0] ctrl;         // Control register
  reg  [15:0] activeCmd;    // Command of the applied value
  reg  [31:0] activeVal;    // Applied parameter value
  reg  [15:0] pendingCmd;   // Command of the held change
  reg  [31:0] pendingVal;   // Held parameter value
  reg         pendingFlag;  // A change waits to be applied
  reg  [7:0]  lastOptions;  // Options of the last executed frame
  reg  [7:0]  lastId;       // Identifier of the last executed frame
  reg  [15:0] goodCount;    // Executed frames
  reg  [15:0] badCount;     // Frames dropped for checksum
  reg  [31:0] readMux;      // APB read data before the flop
  reg         readHit;      // Address decodes to a register

  wire [7:0]  rxSum;
  wire [7:0]  txSum;
  wire [7:0]  pushData;
  wire [15:0] respLen;
  wire        rxFire;
  wire        sumOk;
  wire        isQuery;
  wire        isApplyCmd;
  wire        execOk;
  wire        badFrame;
  wire        bufInReady;
  wire        pushFire;
  wire        lastByte;
  wire        apbAccess;
  wire        apbWrite;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode terms
  assign rxFire     = ce & rxValid & rxReady;
  assign sumOk      = ((`CKSUM_BASE - rxSum) == rxData);
  assign isQuery    = (lenReg == `MIN_BODY_LEN);
  assign isApplyCmd = (cmdWord == `APPLY_PENDING_CHANGES_CMD);
  assign execOk     = rxFire & (state == ST_CKSUM) & sumOk
                    & (typeByte == `TYPE_REMOTE_REQ)
                    & (lenReg >= `MIN_BODY_LEN) & ctrl[`CTRL_ENABLE_BIT];
  assign badFrame   = rxFire & (state == ST_CKSUM) & ~sumOk;
  assign respLen    = isQuery ? `RESP_LEN_QUERY : `RESP_LEN_SET;

  ////////////////////////////////////////////////////////////////////////////
  // Response push terms
  assign lastByte = (respCount == respTotal);
  assign pushFire = ce & (state == ST_RESP) & bufInReady;
  assign pushData = lastByte ? (`CKSUM_BASE - txSum) : respVec[95:88];

  ////////////////////////////////////////////////////////////////////////////
  // Request checksum over offset three up to the checksum
  byte_sum u_rx_sum (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .clear (rxFire & (state == ST_LENLO)),
    .add   (rxFire & (state == ST_BODY)),
    .data  (rxData),
    .sum   (rxSum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Response checksum skips delimiter and length
  byte_sum u_tx_sum (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .clear (execOk),
    .add   (pushFire & ~lastByte & (respCount >= `RESP_HDR_BYTES)),
    .data  (respVec[95:88]),
    .sum   (txSum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer so a host stall loses no response byte
  resp_buffer #(
    .WIDTH (8)
  ) u_resp_buffer (
    .clock    (clock),
    .rst_n    (rst_n),
    .ce       (ce),
    .inValid  (state == ST_RESP),
    .inData   (pushData),
    .inReady  (bufInReady),
    .outValid (txValid),
    .outData  (txData),
    .outReady (txReady)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame parser and response sequencer
  always @(posedge clock) begin
    if (!rst_n) begin
      state     <= ST_HUNT;
      rxReady   <= 1'b1;
      lenReg    <= `LEN_EMPTY;
      ofs       <= `COUNT_ZERO;
      typeByte  <= `BYTE_ZERO;
      frameId   <= `BYTE_ZERO;
      dest64    <= `DEST64_RESET;
      dest16    <= `HALF_ZERO;
      options   <= `BYTE_ZERO;
      cmdWord   <= `HALF_ZERO;
      paramVal  <= `WORD_ZERO;
      respVec   <= {`WORD_ZERO, `WORD_ZERO, `WORD_ZERO};
      respCount <= `COUNT_ZERO;
      respTotal <= `COUNT_ZERO;
    end else if (ce) begin
      case (state)
        ST_HUNT: begin
          if (rxFire && rxData == `START_DELIM) begin
            state <= ST_LENHI;
          end
        end
        ST_LENHI: begin
          if (rxFire) begin
            lenReg[15:8] <= rxData;
            state        <= ST_LENLO;
          end
        end
        ST_LENLO: begin
          if (rxFire) begin
            lenReg[7:0] <= rxData;
            ofs         <= `OFS_FIRST_SUMMED;
            typeByte    <= `BYTE_ZERO;
            paramVal    <= `WORD_ZERO;
            if ({lenReg[15:8], rxData} == `LEN_EMPTY) begin
              state <= ST_CKSUM;
            end else begin
              state <= ST_BODY;
            end
          end
        end
        ST_BODY: begin
          if (rxFire) begin
            ofs <= ofs + `COUNT_ONE;
            if (ofs == `OFS_FIRST_SUMMED) begin
              typeByte <= rxData;
            end else if (ofs == `OFS_FRAME_ID) begin
              frameId <= rxData;
            end else if (ofs >= `OFS_DEST64 && ofs < `OFS_DEST16) begin
              dest64 <= {dest64[55:0], rxData};
            end else if (ofs >= `OFS_DEST16 && ofs < `OFS_OPTIONS) begin
              dest16 <= {dest16[7:0], rxData};
            end else if (ofs == `OFS_OPTIONS) begin
              options <= rxData;
            end else if (ofs == `OFS_CMD_HI) begin
              cmdWord[15:8] <= rxData;
            end else if (ofs == `OFS_CMD_LO) begin
              cmdWord[7:0] <= rxData;
            end else begin
              paramVal <= {paramVal[23:0], rxData};
            end
            if (ofs == lenReg + `BODY_LAST_ADJ) begin
              state <= ST_CKSUM;
            end
          end
        end
        ST_CKSUM: begin
          if (execOk && frameId != `FRAME_ID_NONE) begin
            respVec   <= {`START_DELIM, respLen, `TYPE_REMOTE_RESP,
                          frameId, cmdWord, `RESP_STATUS_OK,
                          isQuery ? activeVal : `WORD_ZERO};
            respCount <= `COUNT_ZERO;
            respTotal <= respLen + `RESP_HDR_BYTES;
            rxReady   <= 1'b0;
            state     <= ST_RESP;
          end else if (rxFire) begin
            state <= ST_HUNT;
          end
        end
        ST_RESP: begin
          if (pushFire) begin
            respCount <= respCount + `COUNT_ONE;
            respVec   <= {respVec[87:0], `BYTE_ZERO};
            if (lastByte) begin
              rxReady <= 1'b1;
              state   <= ST_HUNT;
            end
          end
        end
        default: begin
          rxReady <= 1'b1;
          state   <= ST_HUNT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: ready one cycle into the access phase
  assign apbAccess = psel & penable & pready;
  assign apbWrite  = ce & apbAccess & pwrite;

  always @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `WORD_ZERO;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~readHit;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= readMux;
      end else begin
        prdata <= `WORD_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped addresses read zero with an error
  always @* begin
    readMux = `WORD_ZERO;
    readHit = 1'b1;
    case (paddr)
      `REG_CTRL:          readMux = ctrl;
      `REG_STATUS:        readMux = {`HALF_ZERO, lastId, 3'b000, state == ST_RESP,
                                     lastOptions[`OPT_SECURE],
                                     lastOptions[`OPT_APPLY],
                                     lastOptions[`OPT_NO_ACK], pendingFlag};
      `REG_COUNT:         readMux = {badCount, goodCount};
      `REG_ACTIVE_CMD:    readMux = {`HALF_ZERO, activeCmd};
      `REG_ACTIVE_VALUE:  readMux = activeVal;
      `REG_PENDING_CMD:   readMux = {`HALF_ZERO, pendingCmd};
      `REG_PENDING_VALUE: readMux = pendingVal;
      `REG_DEST:          readMux = {`HALF_ZERO, dest16};
      default:            readHit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter store; a frame that executes wins over a software write
  always @(posedge clock) begin
    if (!rst_n) begin
      ctrl        <= `CTRL_RESET;
      activeCmd   <= `HALF_ZERO;
      activeVal   <= `WORD_ZERO;
      pendingCmd  <= `HALF_ZERO;
      pendingVal  <= `WORD_ZERO;
      pendingFlag <= 1'b0;
      lastOptions <= `BYTE_ZERO;
      lastId      <= `BYTE_ZERO;
    end else if (ce) begin
      if (apbWrite && paddr == `REG_CTRL) begin
        ctrl <= pwdata;
      end
      if (apbWrite && paddr == `REG_ACTIVE_CMD) begin
        activeCmd <= pwdata[15:0];
      end
      if (apbWrite && paddr == `REG_ACTIVE_VALUE) begin
        activeVal <= pwdata;
      end
      if (execOk) begin
        lastOptions <= options;
        lastId      <= frameId;
        if (isApplyCmd) begin
          if (pendingFlag) begin
            activeCmd <= pendingCmd;
            activeVal <= pendingVal;
          end
          pendingFlag <= 1'b0;
        end else if (!isQuery) begin
          pendingCmd <= cmdWord;
          pendingVal <= paramVal;
          if (options[`OPT_APPLY]) begin
            activeCmd   <= cmdWord;
            activeVal   <= paramVal;
            pendingFlag <= 1'b0;
          end else begin
            pendingFlag <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame counters; a write to REG_COUNT clears, a same-cycle event still counts
  always @(posedge clock) begin
    if (!rst_n) begin
      goodCount <= `HALF_ZERO;
      badCount  <= `HALF_ZERO;
    end else if (ce) begin
      if (apbWrite && paddr == `REG_COUNT) begin
        goodCount <= execOk ? `COUNT_ONE : `COUNT_ZERO;
        badCount  <= badFrame ? `COUNT_ONE : `COUNT_ZERO;
      end else begin
        if (execOk) begin
          goodCount <= goodCount + `COUNT_ONE;
        end
        if (badFrame) begin
          badCount <= badCount + `COUNT_ONE;
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> core/resp_buffer.v
`timescale 1ns/1ps
`default_nettype none

module resp_buffer #(
  parameter WIDTH = 8  // Entry width in bits
) (
  input  wire             clock,     // System clock
  input  wire             rst_n,     // Synchronous reset, active low
  input  wire             ce,        // Clock enable
  input  wire             inValid,   // Producer offers an entry
  input  wire [WIDTH-1:0] inData,    // Producer entry
  output wire             inReady,   // Room for one more entry
  output wire             outValid,  // Head entry present
  output wire [WIDTH-1:0] outData,   // Head entry
  input  wire             outReady   // Consumer takes the head
);

  localparam DEPTH = 2;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];  // Slot 0 is always the head
  reg  [DEPTH-1:0] full;             // Occupancy per slot
  wire             push;
  wire             pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes, all outputs are flops
  assign inReady  = ~full[1];
  assign outValid = full[0];
  assign outData  = mem[0];
  assign push     = inValid & ~full[1];
  assign pop      = full[0] & outReady;

  ////////////////////////////////////////////////////////////////////////////
  // Slot moves: pop shifts slot 1 forward, push fills the first free slot
  always @(posedge clock) begin
    if (!rst_n) begin
      full   <= {DEPTH{1'b0}};
      mem[0] <= {WIDTH{1'b0}};
      mem[1] <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (pop && full[1]) begin
        mem[0]  <= mem[1];
        full[1] <= 1'b0;
      end else if (pop) begin
        mem[0]  <= inData;
        full[0] <= push;
      end else if (push && !full[0]) begin
        mem[0]  <= inData;
        full[0] <= 1'b1;
      end else if (push) begin
        mem[1]  <= inData;
        full[1] <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> tb/framer_props.sv
`timescale 1ns/1ps
`default_nettype none

module framer_props #(
  parameter ADDR_WIDTH = 8  // APB address width
) (
  input wire logic                  clock,    // Clock
  input wire logic                  rst_n,    // Reset, active low
  input wire logic                  ce,       // Clock enable
  input wire logic                  rxValid,  // Request byte valid
  input wire logic [7:0]            rxData,   // Request byte
  input wire logic                  rxReady,  // Request byte taken
  input wire logic                  txValid,  // Response byte valid
  input wire logic [7:0]            txData,   // Response byte
  input wire logic                  txReady,  // Response byte taken
  input wire logic [ADDR_WIDTH-1:0] paddr,    // APB address
  input wire logic                  psel,     // APB select
  input wire logic                  penable,  // APB access
  input wire logic                  pwrite,   // APB write
  input wire logic [31:0]           pwdata,   // APB write data
  input wire logic [31:0]           prdata,   // APB read data
  input wire logic                  pready,   // APB ready
  input wire logic                  pslverr   // APB error
);
  logic [7:0] idx;
  logic [7:0] rlen;
  logic [7:0] sum;
  wire        hs = txValid && txReady && ce;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Byte position, length and running sum of the response frame
  always @(posedge clock) begin
    if (!rst_n) begin
      idx  <= 8'h00;
      rlen <= 8'h00;
      sum  <= 8'h00;
    end else if (hs) begin
      idx  <= (idx > 8'h03 && idx == rlen + 8'h03) ? 8'h00 : idx + 8'h01;
      rlen <= (idx == 8'h02) ? txData : rlen;
      sum  <= (idx < 8'h03) ? 8'h00 : sum + txData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  pready_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not after one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("pslverr without pready or with data");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("response byte changed while stalled");
  resp_start_a: assert property (hs && idx == 8'h00 |-> txData == 8'h7E)
    else $error("response does not open with delimiter");
  resp_len_a: assert property (hs && idx == 8'h02 |-> txData == 8'h05 || txData == 8'h09)
    else $error("response length wrong");
  resp_type_a: assert property (hs && idx == 8'h03 |-> txData == 8'h97)
    else $error("response type wrong");
  resp_cksum_a: assert property (hs && idx > 8'h03 && idx == rlen + 8'h03 |-> txData == 8'hFF - sum)
    else $error("response checksum wrong");
  rx_pause_a: assert property ($fell(rxReady) |-> ##[1:3] txValid)
    else $error("request intake paused without response");

  // Main scenarios
  cover property (hs && idx == 8'h03);
  cover property (pslverr);
  cover property (txValid && !txReady);
endmodule

bind remote_cmd_request_framer framer_props #(.ADDR_WIDTH(ADDR_WIDTH)) framer_props_inst (
  .clock(clock), .rst_n(rst_n), .ce(ce), .rxValid(rxValid), .rxData(rxData),
  .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic       clock,    // Clock
  input  wire logic       rst_n,    // Reset, active low
  output var  logic       rxValid,  // Request byte offered
  output var  logic [7:0] rxData,   // Request byte
  input  wire logic       rxReady,  // Block takes the byte
  input  wire logic       txValid,  // Response byte offered
  input  wire logic [7:0] txData,   // Response byte
  output var  logic       txReady,  // Host takes the byte
  input  wire logic       stall     // Throttle the response
);
  logic [7:0] sendQ[$];
  logic [7:0] gotQ[$];
  int         pos = 0;
  logic [1:0] cyc = 2'h0;

  // Frame builder to one fixed unicast destination
  task automatic send(input logic [7:0] id, opt, input logic [15:0] cmd,
                      input int nv, input logic [63:0] v, input bit bad);
    logic [7:0] b[$];
    logic [7:0] s;
    b = {8'h17, id, 8'h00, 8'h13, 8'hA2, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78};
    b = {b, 8'hFF, 8'hFE, opt, cmd[15:8], cmd[7:0]};
    for (int i = nv - 1; i >= 0; i--) b.push_back(v[8*i +: 8]);
    s = 8'hFF - b.sum();
    if (bad) s = ~s;
    sendQ = {sendQ, 8'h7E, 8'h00, 8'(15 + nv), b, s};
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h5A;
    txReady = 1'b0;
  end

  // Offer held until taken; idle line toggles so no stale byte shows
  always @(posedge clock) begin
    if (rxValid && rxReady) pos = pos + 1;
    rxValid <= rst_n && pos < sendQ.size();
    rxData  <= (pos < sendQ.size()) ? sendQ[pos] : ~rxData;
  end

  // Response sink, stalling half the time when asked
  always @(posedge clock) begin
    cyc <= cyc + 2'h1;
    if (txValid && txReady) gotQ.push_back(txData);
    txReady <= rst_n && !(stall && cyc[1]);
  end
endmodule

`default_nettype wire

// >>> tb/remote_cmd_request_framer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "framer_regs.vh"

module remote_cmd_request_framer_tb_top;
  logic        clock   = 1'b0;
  logic        rst_n   = 1'b0;
  logic        ce      = 1'b1;
  logic        stall   = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] rdv;
  logic        ev;
  wire  [31:0] prdata;
  wire         pready, pslverr, rxValid, rxReady, txValid, txReady;
  wire  [7:0]  rxData, txData;
  int          errTotal = 0;
  int          samplesChecked = 0;

  remote_cmd_request_framer #(.ADDR_WIDTH(8)) remote_cmd_request_framer_inst (
    .clock(clock), .rst_n(rst_n), .ce(ce), .rxValid(rxValid), .rxData(rxData),
    .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  host_model host_model_inst (
    .clock(clock), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
    .txValid(txValid), .txData(txData), .txReady(txReady), .stall(stall));

  // Clock, 10 ns period
  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    samplesChecked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      errTotal++;
    end
  endtask

  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0000_0000, rdv, ev);
    chk(nm, x, rdv);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, ev);
    chk("write_err", 32'h0000_0000, {31'h0000_0000, ev});
  endtask

  // Expected response frame compared byte by byte
  task automatic resp(input logic [7:0] id, input logic [15:0] cmd, input bit q,
                      input logic [31:0] v);
    logic [7:0] x[$];
    int n;
    x = {8'h97, id, cmd[15:8], cmd[7:0], 8'h00};
    if (q) x = {x, v[31:24], v[23:16], v[15:8], v[7:0]};
    x = {8'h7E, 8'h00, 8'(x.size()), x, 8'hFF - x.sum()};
    for (n = 0; n < 300 && host_model_inst.gotQ.size() < x.size(); n++) @(posedge clock);
    chk("resp_count", x.size(), host_model_inst.gotQ.size());
    foreach (x[i]) chk("resp_byte", {24'h00_0000, x[i]}, {24'h00_0000, host_model_inst.gotQ[i]});
    host_model_inst.gotQ.delete();
  endtask

  // Frame fully sent, then no response may appear
  task automatic quiet();
    while (host_model_inst.pos < host_model_inst.sendQ.size()) @(posedge clock);
    repeat (30) @(posedge clock);
    chk("no_resp", 32'h0000_0000, host_model_inst.gotQ.size());
  endtask

  task automatic closeOut();
    $display("checks %0d errors %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    errTotal++;
    closeOut();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd(`REG_CTRL, 32'h0000_0001, "ctrl");
    rd(`REG_COUNT, 32'h0000_0000, "count_reset");
    rd(`REG_STATUS, 32'h0000_0000, "status_reset");
    apb(1'b0, 8'h40, 32'h0000_0000, rdv, ev);
    chk("unmapped_err", 32'h0000_0001, {31'h0000_0000, ev});
    chk("unmapped_data", 32'h0000_0000, rdv);
    wr(`REG_ACTIVE_VALUE, 32'h1234_5678);
    stall <= 1'b1;
    host_model_inst.send(8'hFA, 8'h00, 16'h5450, 0, 64'h0, 1'b0);
    resp(8'hFA, 16'h5450, 1'b1, 32'h1234_5678);
    stall <= 1'b0;
    host_model_inst.send(8'h27, 8'h02, 16'h4E49, 6, 64'h0000_5265_6D6F_7465, 1'b0);
    resp(8'h27, 16'h4E49, 1'b0, 32'h0000_0000);
    rd(`REG_ACTIVE_VALUE, 32'h6D6F_7465, "active_value");
    rd(`REG_ACTIVE_CMD, 32'h0000_4E49, "active_cmd");
    rd(`REG_STATUS, 32'h0000_2704, "status_apply");
    host_model_inst.send(8'h68, 8'h11, 16'h4944, 2, 64'h0451, 1'b0);
    resp(8'h68, 16'h4944, 1'b0, 32'h0000_0000);
    rd(`REG_PENDING_VALUE, 32'h0000_0451, "pending_value");
    rd(`REG_PENDING_CMD, 32'h0000_4944, "pending_cmd");
    rd(`REG_ACTIVE_VALUE, 32'h6D6F_7465, "held_value");
    rd(`REG_STATUS, 32'h0000_680B, "status_pending");
    wr(`REG_PENDING_VALUE, 32'hFFFF_FFFF);
    rd(`REG_PENDING_VALUE, 32'h0000_0451, "pending_readonly");
    host_model_inst.send(8'h00, 8'h00, `APPLY_PENDING_CHANGES_CMD, 0, 64'h0, 1'b0);
    quiet();
    rd(`REG_ACTIVE_VALUE, 32'h0000_0451, "applied_value");
    rd(`REG_STATUS, 32'h0000_0000, "status_applied");
    host_model_inst.send(8'h55, 8'h02, 16'h4E49, 1, 64'h0099, 1'b1);
    quiet();
    rd(`REG_ACTIVE_VALUE, 32'h0000_0451, "bad_frame_value");
    rd(`REG_COUNT, 32'h0001_0004, "count");
    wr(`REG_COUNT, 32'h0000_0000);
    rd(`REG_COUNT, 32'h0000_0000, "count_clear");
    rd(`REG_DEST, 32'h0000_FFFE, "dest16");
    wr(`REG_CTRL, 32'h0000_0000);
    host_model_inst.send(8'h31, 8'h02, 16'h4E49, 1, 64'h77, 1'b0);
    quiet();
    closeOut();
  end
endmodule

`default_nettype wire
